// ### common/pdd_map.vh
// Register map, field positions, reset values and display codes of the panel display block
// Operation
// RQ1: 16-bit decimal fills five digits, leading zeros pad short values.
// RQ2: 16-bit hex uses four right digits, leftmost digit blank.
// RQ3: 32-bit decimal splits high/low screens; low is five LSDs; point marks high.
// RQ4: 32-bit hex splits halves; upper prefixed h glyph, lower L glyph.
// RQ5: Negative decimal lights two leftmost points; hex never shows a sign.
// RQ6: Monitor and edit displays use the same formatting.
// RQ7: Monitor 32-bit values switch half and radix; parameters keep fixed format.
// RQ8: Set key on a fault history entry shows its stored fault record.
// RQ9: Set on jog speed shows speed, default 20; up/down adjust it.
// RQ10: Second set press shows jog indication and enters jog mode.
// RQ11: Jog: up held runs forward, down held reverse, release stops.
// RQ12: Jog motion only while the drive is servo-on.
// RQ13: Writing 406 to special function parameter enters forced-output mode.
// RQ14: Forced pattern is a binary mask, bit n forces output n+1.
// RQ15: Forced pattern is not retained; it is lost when the mode ends.
// RQ16: Forced mode ends on power cycling or special function write of 400.
// RQ17: Forced pattern shown in hex, leftmost digit blank.
// RQ18: Input diagnosis shows nine input lines as hex bits, set means active.
// RQ19: Output diagnosis shows six output lines as hex bits, set means active.
`ifndef PDD_MAP_VH
`define PDD_MAP_VH

`define PDD_ADDR_CTRL        8'h00
`define PDD_ADDR_MON_LO      8'h04
`define PDD_ADDR_MON_HI      8'h08
`define PDD_ADDR_EDIT_VAL    8'h0C
`define PDD_ADDR_PARAM_SEL   8'h10
`define PDD_ADDR_SPECIAL_FN  8'h14
`define PDD_ADDR_JOG_SPEED   8'h18
`define PDD_ADDR_FORCE_PAT   8'h1C
`define PDD_ADDR_FAULT_BASE  8'h20
`define PDD_ADDR_FAULT_LAST  8'h30
`define PDD_ADDR_STATUS      8'h34
`define PDD_ADDR_DISPLAY     8'h38

`define PDD_CTRL_VIEW_LSB    0
`define PDD_CTRL_MON_HEX     3
`define PDD_CTRL_MON_HIGH    4
`define PDD_CTRL_MON_32      5
`define PDD_CTRL_MON_SIGNED  6

`define PDD_VIEW_PANEL       3'h0
`define PDD_VIEW_MONITOR     3'h1
`define PDD_VIEW_DI_DIAG     3'h2
`define PDD_VIEW_DO_DIAG     3'h3
`define PDD_VIEW_FORCE_PAT   3'h4

`define PDD_SEL_JOG_SPEED    4'h5
`define PDD_FAULT_ENTRIES    5

`define PDD_SPECIAL_FORCE_ON  16'h0196
`define PDD_SPECIAL_FORCE_OFF 16'h0190

`define PDD_JOG_SPEED_RST    16'h0014
`define PDD_CTRL_RST         7'h00

`define PDD_GLYPH_BLANK      5'h10
`define PDD_GLYPH_HIGH       5'h11
`define PDD_GLYPH_LOW        5'h12
`define PDD_GLYPH_J          5'h13
`define PDD_GLYPH_G          5'h14

`endif

// ### src/pdd_bin2bcd.v
// Sequential binary to ten-digit BCD converter
`timescale 1ns/100ps
module pdd_bin2bcd (
  input  wire        clock,
  input  wire        arst_n,
  input  wire        start,
  input  wire [31:0] bin,
  output reg         busy_reg,
  output reg         done_reg,
  output reg  [39:0] bcd_reg
);

  reg [31:0] shift_reg;
  reg [39:0] acc_reg;
  reg [5:0]  count_reg;
  wire [39:0] adj;

  function [39:0] add3;
    input [39:0] a;
    integer i;
    begin
      add3 = a;
      for (i = 0; i < 10; i = i + 1) begin
        if (a[i*4 +: 4] > 4'h4)
          add3[i*4 +: 4] = a[i*4 +: 4] + 4'h3;
      end
    end
  endfunction

  assign adj = add3(acc_reg);

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      shift_reg <= 32'h0000_0000;
      acc_reg   <= 40'h00_0000_0000;
      count_reg <= 6'h00;
      busy_reg  <= 1'b0;
      done_reg  <= 1'b0;
      bcd_reg   <= 40'h00_0000_0000;
    end else begin
      done_reg <= 1'b0;
      if (!busy_reg) begin
        if (start) begin
          shift_reg <= bin;
          acc_reg   <= 40'h00_0000_0000;
          count_reg <= 6'h20;
          busy_reg  <= 1'b1;
        end
      end else begin
        acc_reg   <= {adj[38:0], shift_reg[31]};
        shift_reg <= {shift_reg[30:0], 1'b0};
        count_reg <= count_reg - 6'h01;
        if (count_reg == 6'h01) begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
          bcd_reg  <= {adj[38:0], shift_reg[31]};
        end
      end
    end
  end

endmodule

// ### src/pdd_panel.v
// Front-panel display formatter, fault/jog key handling and forced-output diagnosis
`timescale 1ns/100ps
`include "pdd_map.vh"
module pdd_panel #(
  parameter DI_LINES = 9,
  parameter DO_LINES = 6
) (
  input  wire                clock,
  input  wire                arst_n,
  input  wire [7:0]          addr,
  input  wire [31:0]         wdata,
  input  wire                wr_stb,
  input  wire                rd_stb,
  output reg  [31:0]         rdata_reg,
  input  wire                key_set,
  input  wire                key_mode,
  input  wire                key_up,
  input  wire                key_down,
  input  wire                servo_on,
  input  wire [DI_LINES-1:0] di_lines,
  input  wire [DO_LINES-1:0] do_normal,
  output reg  [DO_LINES-1:0] do_lines_reg,
  output reg                 force_mode_reg,
  output reg                 jog_fwd_reg,
  output reg                 jog_rev_reg,
  output reg  [15:0]         jog_speed_reg,
  output reg  [24:0]         disp_code_reg,
  output reg  [4:0]          disp_dp_reg
);

  localparam ST_BROWSE = 2'd0;
  localparam ST_FAULT  = 2'd1;
  localparam ST_JOGSPD = 2'd2;
  localparam ST_JOGRUN = 2'd3;

  reg [6:0]  ctrl_reg;
  reg [31:0] mon_reg;
  reg [15:0] edit_val_reg;
  reg [3:0]  param_sel_reg;
  reg [15:0] special_fn_reg;
  reg [15:0] force_pat_reg;
  reg [15:0] fault_mem [0:`PDD_FAULT_ENTRIES-1];
  reg [1:0]  state_reg;
  reg [1:0]  state_next;
  reg [2:0]  fault_idx_reg;
  reg        set_q_reg;
  reg        mode_q_reg;
  reg        up_q_reg;
  reg        down_q_reg;
  reg [31:0] lat_val_reg;
  reg        lat_32_reg;
  reg        lat_hex_reg;
  reg        lat_high_reg;
  reg        lat_neg_reg;
  reg        lat_jog_reg;
  reg [31:0] src_val;
  reg        f_32;
  reg        f_hex;
  reg        f_high;
  reg        f_signed;
  reg        f_neg;
  reg [31:0] mag;
  reg [24:0] code_next;
  reg [4:0]  dp_next;
  reg [31:0] rd_next;
  integer    k;

  wire        set_edge  = key_set & ~set_q_reg;
  wire        mode_edge = key_mode & ~mode_q_reg;
  wire        up_edge   = key_up & ~up_q_reg;
  wire        down_edge = key_down & ~down_q_reg;
  wire [2:0]  view      = ctrl_reg[`PDD_CTRL_VIEW_LSB +: 3];
  wire        conv_busy;
  wire        conv_done;
  wire [39:0] conv_bcd;
  wire        conv_start = ~conv_busy & ~conv_done;
  wire        fault_sel  = (param_sel_reg < `PDD_FAULT_ENTRIES);
  wire        wr_fault   = wr_stb && (addr >= `PDD_ADDR_FAULT_BASE) &&
                           (addr <= `PDD_ADDR_FAULT_LAST) && (addr[1:0] == 2'b00);
  wire [2:0]  wr_fidx    = addr[4:2];

  function [4:0] nib;
    input [3:0] n;
    begin
      nib = {1'b0, n};
    end
  endfunction

  // Fault records keep five codes, each the last one the firmware wrote to its own fault address
  always @(posedge clock) begin
    if (wr_fault)
      fault_mem[wr_fidx] <= wdata[15:0];
  end

  // Register writes
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg       <= `PDD_CTRL_RST;
      mon_reg        <= 32'h0000_0000;
      edit_val_reg   <= 16'h0000;
      param_sel_reg  <= 4'h0;
      special_fn_reg <= 16'h0000;
      force_pat_reg  <= 16'h0000;
      force_mode_reg <= 1'b0; // RQ16
    end else if (wr_stb) begin
      if (addr == `PDD_ADDR_CTRL) begin
        ctrl_reg <= wdata[6:0];
      end else if (addr == `PDD_ADDR_MON_LO) begin
        mon_reg[15:0] <= wdata[15:0];
      end else if (addr == `PDD_ADDR_MON_HI) begin
        mon_reg[31:16] <= wdata[15:0];
      end else if (addr == `PDD_ADDR_EDIT_VAL) begin
        edit_val_reg <= wdata[15:0];
      end else if (addr == `PDD_ADDR_PARAM_SEL) begin
        param_sel_reg <= wdata[3:0];
      end else if (addr == `PDD_ADDR_SPECIAL_FN) begin
        special_fn_reg <= wdata[15:0];
        if (wdata[15:0] == `PDD_SPECIAL_FORCE_ON) begin
          force_mode_reg <= 1'b1; // RQ13
        end else if (wdata[15:0] == `PDD_SPECIAL_FORCE_OFF) begin
          force_mode_reg <= 1'b0; // RQ16
          force_pat_reg  <= 16'h0000; // RQ15
        end
      end else if (addr == `PDD_ADDR_FORCE_PAT) begin
        // Pattern only accepted inside the mode, nothing survives outside it
        if (force_mode_reg)
          force_pat_reg <= wdata[15:0]; // RQ15
      end
    end
  end

  // Panel key sequence
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_BROWSE: begin
        if (set_edge && fault_sel)
          state_next = ST_FAULT; // RQ8
        else if (set_edge && param_sel_reg == `PDD_SEL_JOG_SPEED)
          state_next = ST_JOGSPD; // RQ9
      end
      ST_FAULT: begin
        if (mode_edge || set_edge)
          state_next = ST_BROWSE;
      end
      ST_JOGSPD: begin
        if (set_edge)
          state_next = ST_JOGRUN; // RQ10
        else if (mode_edge)
          state_next = ST_BROWSE;
      end
      default: begin
        if (mode_edge)
          state_next = ST_BROWSE;
      end
    endcase
  end

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg     <= ST_BROWSE;
      fault_idx_reg <= 3'h0;
      set_q_reg     <= 1'b0;
      mode_q_reg    <= 1'b0;
      up_q_reg      <= 1'b0;
      down_q_reg    <= 1'b0;
      jog_speed_reg <= `PDD_JOG_SPEED_RST; // RQ9
      jog_fwd_reg   <= 1'b0;
      jog_rev_reg   <= 1'b0;
      do_lines_reg  <= {DO_LINES{1'b0}};
    end else begin
      state_reg  <= state_next;
      set_q_reg  <= key_set;
      mode_q_reg <= key_mode;
      up_q_reg   <= key_up;
      down_q_reg <= key_down;
      if (state_reg == ST_BROWSE && set_edge && fault_sel)
        fault_idx_reg <= param_sel_reg[2:0]; // RQ8
      if (wr_stb && addr == `PDD_ADDR_JOG_SPEED) begin
        jog_speed_reg <= wdata[15:0];
      end else if (state_reg == ST_JOGSPD) begin
        // Saturate instead of wrapping so a key press at 0 or FFFF never flips the speed
        if (up_edge && jog_speed_reg != 16'hFFFF)
          jog_speed_reg <= jog_speed_reg + 16'h0001; // RQ9
        else if (down_edge && jog_speed_reg != 16'h0000)
          jog_speed_reg <= jog_speed_reg - 16'h0001; // RQ9
      end
      // Both keys together is ambiguous, so the motor stays still
      jog_fwd_reg <= (state_next == ST_JOGRUN) && servo_on && key_up && !key_down; // RQ11 RQ12
      jog_rev_reg <= (state_next == ST_JOGRUN) && servo_on && key_down && !key_up; // RQ11 RQ12
      do_lines_reg <= force_mode_reg ? force_pat_reg[DO_LINES-1:0] : do_normal; // RQ14
    end
  end

  // Source and format of what the panel shows
  always @* begin
    src_val  = 32'h0000_0000;
    f_32     = 1'b0;
    f_hex    = 1'b0;
    f_high   = 1'b0;
    f_signed = 1'b0;
    if (view == `PDD_VIEW_MONITOR) begin
      src_val  = mon_reg;
      f_32     = ctrl_reg[`PDD_CTRL_MON_32]; // RQ7
      f_hex    = ctrl_reg[`PDD_CTRL_MON_HEX]; // RQ7
      f_high   = ctrl_reg[`PDD_CTRL_MON_HIGH]; // RQ7
      f_signed = ctrl_reg[`PDD_CTRL_MON_SIGNED];
    end else if (view == `PDD_VIEW_DI_DIAG) begin
      src_val = {{(32-DI_LINES){1'b0}}, di_lines}; // RQ18
      f_hex   = 1'b1;
    end else if (view == `PDD_VIEW_DO_DIAG) begin
      src_val = {{(32-DO_LINES){1'b0}}, do_lines_reg}; // RQ19
      f_hex   = 1'b1;
    end else if (view == `PDD_VIEW_FORCE_PAT) begin
      src_val = {16'h0000, force_pat_reg};
      f_hex   = 1'b1; // RQ17
    end else if (state_reg == ST_FAULT) begin
      src_val = {16'h0000, fault_mem[fault_idx_reg]}; // RQ8
      f_hex   = 1'b1;
    end else if (state_reg == ST_JOGSPD) begin
      src_val = {16'h0000, jog_speed_reg}; // RQ9
    end else begin
      // Parameters carry one fixed format: signed 16-bit decimal
      src_val  = {16'h0000, edit_val_reg}; // RQ6 RQ7
      f_signed = 1'b1;
    end
    f_neg = ~f_hex & f_signed & (f_32 ? src_val[31] : src_val[15]); // RQ5
    if (f_neg)
      mag = f_32 ? (32'h0000_0000 - src_val) : {16'h0000, 16'h0000 - src_val[15:0]};
    else
      mag = f_32 ? src_val : {16'h0000, src_val[15:0]};
  end

  pdd_bin2bcd u_bcd (
    .clock    (clock),
    .arst_n   (arst_n),
    .start    (conv_start),
    .bin      (mag),
    .busy_reg (conv_busy),
    .done_reg (conv_done),
    .bcd_reg  (conv_bcd)
  );

  // The format is latched with the conversion so digits and points always agree
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lat_val_reg  <= 32'h0000_0000;
      lat_32_reg   <= 1'b0;
      lat_hex_reg  <= 1'b0;
      lat_high_reg <= 1'b0;
      lat_neg_reg  <= 1'b0;
      lat_jog_reg  <= 1'b0;
    end else if (conv_start) begin
      lat_val_reg  <= mag;
      lat_32_reg   <= f_32;
      lat_hex_reg  <= f_hex;
      lat_high_reg <= f_high;
      lat_neg_reg  <= f_neg;
      lat_jog_reg  <= (view == `PDD_VIEW_PANEL) && (state_reg == ST_JOGRUN);
    end
  end

  always @* begin
    code_next = 25'h000_0000;
    dp_next   = 5'h00;
    if (lat_jog_reg) begin
      code_next = {`PDD_GLYPH_BLANK, `PDD_GLYPH_J, nib(4'h0), `PDD_GLYPH_G,
                   `PDD_GLYPH_BLANK}; // RQ10
    end else if (lat_hex_reg) begin
      if (!lat_32_reg)
        code_next = {`PDD_GLYPH_BLANK, nib(lat_val_reg[15:12]), nib(lat_val_reg[11:8]),
                     nib(lat_val_reg[7:4]), nib(lat_val_reg[3:0])}; // RQ2
      else if (lat_high_reg)
        code_next = {`PDD_GLYPH_HIGH, nib(lat_val_reg[31:28]), nib(lat_val_reg[27:24]),
                     nib(lat_val_reg[23:20]), nib(lat_val_reg[19:16])}; // RQ4
      else
        code_next = {`PDD_GLYPH_LOW, nib(lat_val_reg[15:12]), nib(lat_val_reg[11:8]),
                     nib(lat_val_reg[7:4]), nib(lat_val_reg[3:0])}; // RQ4
    end else begin
      for (k = 0; k < 5; k = k + 1) begin
        if (lat_32_reg && lat_high_reg)
          code_next[k*5 +: 5] = nib(conv_bcd[20 + k*4 +: 4]); // RQ3
        else
          code_next[k*5 +: 5] = nib(conv_bcd[k*4 +: 4]); // RQ1 RQ3
      end
      if (lat_32_reg && lat_high_reg)
        dp_next[1] = 1'b1; // RQ3
      if (lat_neg_reg)
        dp_next[4:3] = 2'b11; // RQ5
    end
  end

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      disp_code_reg <= {5{`PDD_GLYPH_BLANK}};
      disp_dp_reg   <= 5'h00;
    end else if (conv_done) begin
      disp_code_reg <= code_next; // RQ6
      disp_dp_reg   <= dp_next;
    end
  end

  // Register reads, answered in the cycle after the strobe
  always @* begin
    rd_next = 32'h0000_0000;
    if (addr == `PDD_ADDR_CTRL) begin
      rd_next = {25'h000_0000, ctrl_reg};
    end else if (addr == `PDD_ADDR_MON_LO) begin
      rd_next = {16'h0000, mon_reg[15:0]};
    end else if (addr == `PDD_ADDR_MON_HI) begin
      rd_next = {16'h0000, mon_reg[31:16]};
    end else if (addr == `PDD_ADDR_EDIT_VAL) begin
      rd_next = {16'h0000, edit_val_reg};
    end else if (addr == `PDD_ADDR_PARAM_SEL) begin
      rd_next = {28'h000_0000, param_sel_reg};
    end else if (addr == `PDD_ADDR_SPECIAL_FN) begin
      rd_next = {16'h0000, special_fn_reg};
    end else if (addr == `PDD_ADDR_JOG_SPEED) begin
      rd_next = {16'h0000, jog_speed_reg};
    end else if (addr == `PDD_ADDR_FORCE_PAT) begin
      rd_next = {16'h0000, force_pat_reg};
    end else if (addr >= `PDD_ADDR_FAULT_BASE && addr <= `PDD_ADDR_FAULT_LAST &&
                 addr[1:0] == 2'b00) begin
      rd_next = {16'h0000, fault_mem[addr[4:2]]};
    end else if (addr == `PDD_ADDR_STATUS) begin
      rd_next = {26'h000_0000, jog_rev_reg, jog_fwd_reg, force_mode_reg, servo_on, state_reg};
    end else if (addr == `PDD_ADDR_DISPLAY) begin
      rd_next = {2'b00, disp_dp_reg, disp_code_reg};
    end
  end

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n)
      rdata_reg <= 32'h0000_0000;
    else if (rd_stb)
      rdata_reg <= rd_next;
    else
      rdata_reg <= 32'h0000_0000;
  end

endmodule

// ### tb/pdd_panel_properties.sv
// Port-level assertions for the panel display block
`timescale 1ns/100ps
`include "pdd_map.vh"
module pdd_panel_props #(
  parameter DI_LINES = 9,
  parameter DO_LINES = 6
) (
  input wire                clock,
  input wire                arst_n,
  input wire [7:0]          addr,
  input wire [31:0]         wdata,
  input wire                wr_stb,
  input wire                rd_stb,
  input wire [31:0]         rdata_reg,
  input wire                key_set,
  input wire                key_mode,
  input wire                key_up,
  input wire                key_down,
  input wire                servo_on,
  input wire [DI_LINES-1:0] di_lines,
  input wire [DO_LINES-1:0] do_normal,
  input wire [DO_LINES-1:0] do_lines_reg,
  input wire                force_mode_reg,
  input wire                jog_fwd_reg,
  input wire                jog_rev_reg,
  input wire [15:0]         jog_speed_reg,
  input wire [24:0]         disp_code_reg,
  input wire [4:0]          disp_dp_reg
);
  logic [2:0] view_q;
  logic [7:0] age_q;
  wire        fn_wr;

  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);

  assign fn_wr = wr_stb && addr == `PDD_ADDR_SPECIAL_FN;

  // Age since the last control register write, so the display has had time to refresh
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      view_q <= 3'h0;
      age_q  <= 8'h00;
    end else if (wr_stb && addr == `PDD_ADDR_CTRL) begin
      view_q <= wdata[2:0];
      age_q  <= 8'h00;
    end else if (age_q != 8'hff) begin
      age_q <= age_q + 8'h01;
    end
  end

  a_force_enter: assert property (
    fn_wr && wdata[15:0] == `PDD_SPECIAL_FORCE_ON |=> force_mode_reg)
    else $error("forced mode not entered");
  a_force_exit: assert property (
    fn_wr && wdata[15:0] == `PDD_SPECIAL_FORCE_OFF |=> !force_mode_reg)
    else $error("forced mode not left");
  a_force_stays: assert property (
    force_mode_reg && !(fn_wr && wdata[15:0] == `PDD_SPECIAL_FORCE_OFF) |=> force_mode_reg)
    else $error("forced mode dropped without exit code");
  a_outputs_follow: assert property (
    arst_n && !force_mode_reg |=> do_lines_reg == $past(do_normal))
    else $error("outputs not following normal control");
  a_jog_fwd_cause: assert property (
    jog_fwd_reg |-> $past(key_up && !key_down && servo_on))
    else $error("forward jog without cause");
  a_jog_rev_cause: assert property (
    jog_rev_reg |-> $past(key_down && !key_up && servo_on))
    else $error("reverse jog without cause");
  a_pattern_blank: assert property (
    view_q >= 3'h2 && view_q <= 3'h4 && age_q >= 8'h78
      |-> disp_code_reg[24:20] == `PDD_GLYPH_BLANK)
    else $error("leftmost digit lit in a bit pattern view");
  a_rdata_idle: assert property (
    !rd_stb |=> rdata_reg == 32'h0000_0000)
    else $error("read data present without a read");

  c_force: cover property (fn_wr ##1 force_mode_reg);
  c_jog_fwd: cover property ($rose(jog_fwd_reg));
  c_jog_rev: cover property ($rose(jog_rev_reg));
endmodule

bind pdd_panel pdd_panel_props #(.DI_LINES(DI_LINES), .DO_LINES(DO_LINES)) u_props (
  .clock(clock), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
  .rd_stb(rd_stb), .rdata_reg(rdata_reg), .key_set(key_set), .key_mode(key_mode),
  .key_up(key_up), .key_down(key_down), .servo_on(servo_on), .di_lines(di_lines),
  .do_normal(do_normal), .do_lines_reg(do_lines_reg), .force_mode_reg(force_mode_reg),
  .jog_fwd_reg(jog_fwd_reg), .jog_rev_reg(jog_rev_reg), .jog_speed_reg(jog_speed_reg),
  .disp_code_reg(disp_code_reg), .disp_dp_reg(disp_dp_reg));

// ### tb/pdd_panel_tb.sv
// Self-checking bench for the panel display block
`timescale 1ns/100ps
`include "pdd_map.vh"
module pdd_panel_tb;
  localparam logic [4:0] bl = `PDD_GLYPH_BLANK;
  logic        clock;
  logic        arst_n;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr_stb;
  logic        rd_stb;
  logic [3:0]  keys;
  logic        servo_on;
  logic [8:0]  di_lines;
  logic [5:0]  do_normal;
  wire  [31:0] rdata;
  wire  [5:0]  do_lines;
  wire         force_mode;
  wire         jog_fwd;
  wire         jog_rev;
  wire  [15:0] jog_speed;
  wire  [24:0] disp_code;
  wire  [4:0]  disp_dp;
  int          bad_count;
  int          checks;
  logic [31:0] rv;
  int          i;

  pdd_panel DUT (
    .clock(clock), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata_reg(rdata), .key_set(keys[0]), .key_mode(keys[1]),
    .key_up(keys[2]), .key_down(keys[3]), .servo_on(servo_on), .di_lines(di_lines),
    .do_normal(do_normal), .do_lines_reg(do_lines), .force_mode_reg(force_mode),
    .jog_fwd_reg(jog_fwd), .jog_rev_reg(jog_rev), .jog_speed_reg(jog_speed),
    .disp_code_reg(disp_code), .disp_dp_reg(disp_dp));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr_stb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic settle();
    repeat (2) @(posedge clock);
    #1;
  endtask

  task automatic state(input logic [1:0] exp);
    rd(`PDD_ADDR_STATUS, rv);
    chk("panel state", exp, rv[1:0]);
  endtask

  // Polls the display register, since refresh waits on the converter
  task automatic disp(input logic [29:0] exp);
    int n;
    n = 0;
    do begin
      rd(`PDD_ADDR_DISPLAY, rv);
      n++;
    end while (rv[29:0] !== exp && n < 100);
    chk("display", {2'b00, exp}, rv);
    chk("display port", {2'b00, exp}, {2'b00, disp_dp, disp_code});
  endtask

  function automatic logic [29:0] dv(input logic [4:0] dp, input logic [4:0] c4,
                                     input logic [15:0] v);
    return {dp, c4, 1'b0, v[15:12], 1'b0, v[11:8], 1'b0, v[7:4], 1'b0, v[3:0]};
  endfunction

  task automatic mon(input logic [6:0] c, input logic [15:0] lo, input logic [15:0] hi,
                     input logic [29:0] exp);
    wr(`PDD_ADDR_CTRL, c);
    wr(`PDD_ADDR_MON_LO, lo);
    wr(`PDD_ADDR_MON_HI, hi);
    disp(exp);
  endtask

  task automatic press(input int k);
    @(posedge clock);
    keys[k] <= 1'b1;
    @(posedge clock);
    keys[k] <= 1'b0;
    repeat (2) @(posedge clock);
  endtask

  task automatic hold(input logic [3:0] m, input logic so, input logic [1:0] exp);
    @(posedge clock);
    keys <= m;
    servo_on <= so;
    repeat (3) @(posedge clock);
    #1 chk("jog drive", exp, {jog_rev, jog_fwd});
    @(posedge clock);
    keys <= 4'h0;
    repeat (3) @(posedge clock);
    #1 chk("jog stop", 2'b00, {jog_rev, jog_fwd});
  endtask

  initial begin
    repeat (50000) @(posedge clock);
    bad_count++;
    stop_test();
  end

  initial begin
    arst_n = 1'b0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    keys = 4'h0;
    servo_on = 1'b0;
    di_lines = 9'h1E1;
    do_normal = 6'h38;
    checks = 0;
    bad_count = 0;
    repeat (20) @(posedge clock);
    arst_n <= 1'b1;
    settle();
    chk("jog speed", 16'h0014, jog_speed);
    chk("forced mode", 1'b0, force_mode);
    chk("outputs", 6'h38, do_lines);
    $display("done reset");

    mon(7'h01, 16'h04D2, 16'h0000, dv(5'h00, 5'h00, 16'h1234));
    mon(7'h09, 16'h1234, 16'h0000, dv(5'h00, bl, 16'h1234));
    mon(7'h21, 16'h02D2, 16'h4996, dv(5'h00, 5'h06, 16'h7890));
    mon(7'h31, 16'h02D2, 16'h4996, dv(5'h02, 5'h01, 16'h2345));
    mon(7'h29, 16'h5678, 16'h1234, dv(5'h00, `PDD_GLYPH_LOW, 16'h5678));
    mon(7'h39, 16'h5678, 16'h1234, dv(5'h00, `PDD_GLYPH_HIGH, 16'h1234));
    mon(7'h61, 16'hFD2E, 16'hB669, dv(5'h18, 5'h06, 16'h7890));
    mon(7'h71, 16'hFD2E, 16'hB669, dv(5'h1A, 5'h01, 16'h2345));
    mon(7'h41, 16'hCFC7, 16'hFFFF, dv(5'h18, 5'h01, 16'h2345));
    mon(7'h49, 16'hCFC7, 16'hFFFF, dv(5'h00, bl, 16'hCFC7));
    wr(`PDD_ADDR_CTRL, 7'h00);
    wr(`PDD_ADDR_PARAM_SEL, 16'h0006);
    wr(`PDD_ADDR_EDIT_VAL, 16'hCFC7);
    disp(dv(5'h18, 5'h01, 16'h2345));
    $display("done formats");

    for (i = 0; i < 5; i++) begin
      wr(`PDD_ADDR_FAULT_BASE + 8'(4 * i), 16'h0A10 + 16'(i));
      wr(`PDD_ADDR_PARAM_SEL, i);
      press(0);
      state(2'h1);
      disp(dv(5'h00, bl, 16'h0A10 + 16'(i)));
      press(1);
      state(2'h0);
    end
    $display("done faults");

    wr(`PDD_ADDR_PARAM_SEL, `PDD_SEL_JOG_SPEED);
    press(0);
    state(2'h2);
    disp(dv(5'h00, 5'h00, 16'h0020));
    for (i = 0; i < 80; i++) press(2);
    press(3);
    press(2);
    chk("jog speed", 16'h0064, jog_speed);
    rd(`PDD_ADDR_JOG_SPEED, rv);
    chk("jog speed reg", 16'h0064, rv);
    disp(dv(5'h00, 5'h00, 16'h0100));
    press(0);
    state(2'h3);
    disp({5'h00, bl, `PDD_GLYPH_J, 5'h00, `PDD_GLYPH_G, bl});
    hold(4'h4, 1'b0, 2'b00);
    hold(4'h4, 1'b1, 2'b01);
    hold(4'h8, 1'b1, 2'b10);
    hold(4'hC, 1'b1, 2'b00);
    press(1);
    state(2'h0);
    $display("done jog");

    wr(`PDD_ADDR_FORCE_PAT, 16'h0003);
    wr(`PDD_ADDR_SPECIAL_FN, `PDD_SPECIAL_FORCE_ON);
    settle();
    chk("forced mode", 1'b1, force_mode);
    chk("outputs", 6'h00, do_lines);
    wr(`PDD_ADDR_FORCE_PAT, 16'h0005);
    settle();
    chk("outputs", 6'h05, do_lines);
    wr(`PDD_ADDR_CTRL, 7'h04);
    disp(dv(5'h00, bl, 16'h0005));
    wr(`PDD_ADDR_CTRL, 7'h03);
    // The pattern view shows the same digits, so wait for a frame of the new view
    repeat (80) @(posedge clock);
    disp(dv(5'h00, bl, 16'h0005));
    wr(`PDD_ADDR_FORCE_PAT, 16'h0002);
    settle();
    chk("outputs", 6'h02, do_lines);
    wr(`PDD_ADDR_SPECIAL_FN, `PDD_SPECIAL_FORCE_OFF);
    settle();
    chk("forced mode", 1'b0, force_mode);
    chk("outputs", 6'h38, do_lines);
    disp(dv(5'h00, bl, 16'h0038));
    rd(`PDD_ADDR_FORCE_PAT, rv);
    chk("pattern", 32'h0000_0000, rv);
    wr(`PDD_ADDR_SPECIAL_FN, `PDD_SPECIAL_FORCE_ON);
    settle();
    chk("outputs", 6'h00, do_lines);
    // Power cycling inside forced mode
    @(posedge clock);
    arst_n <= 1'b0;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    settle();
    chk("forced mode", 1'b0, force_mode);
    chk("outputs", 6'h38, do_lines);
    chk("jog speed", 16'h0014, jog_speed);
    wr(`PDD_ADDR_SPECIAL_FN, `PDD_SPECIAL_FORCE_OFF);
    $display("done forced outputs");

    wr(`PDD_ADDR_CTRL, 7'h02);
    disp(dv(5'h00, bl, 16'h01E1));
    rd(8'h3C, rv);
    chk("unmapped read", 32'h0000_0000, rv);
    $display("done diagnosis");
    stop_test();
  end
endmodule
